/* pcm_pins_pkg.sv */
// Package: constants, carrier types and enums for the PCM highway pin block
// Function
// (R1) Frame sync: input at 8 kHz or 4 kHz, output at 8 kHz only.
// (R2) With 4 kHz frame sync input, bit clock must be a 2.048 MHz input.
// (R3) Bit clock is input or output at 2.048, 4.096, 8.192 or 16.384 MHz; the generated clock has a fixed 800 ns period that bc_rate does not set.
// (R4) Each driver enable is low exactly while its port sends valid data.
// (R5) Transmit pins of ports 0 and 1 float in reset; push-pull or open-drain.
// (R6) Transmit pins 2 and 3 weakly low; async mode uses them as channel clocks.
// (R7) Async mode: port 0 pins carry channel 2 data, port 1 pins channel 3.
// (R8) Async mode: port 0 enable is channel 2 send request, port 2 input its clear.
// (R9) Async mode: port 1 enable is channel 3 send request, port 3 input its clear.
// (R10) Driver enables are sampled as straps in reset, then driven high.
package pcm_pins_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int BCLK_GEN_NS = 800;
	localparam int BCLK_HALF_CYC = (BCLK_GEN_NS * (CLK_HZ / 1_000_000)) / 2000;
	localparam int DIV_W = 3;
	localparam int FRAME_BITS = 256;
	localparam int SLOT_BITS = 8;
	localparam int PORTS = 4;
	localparam int BUF_DEPTH = 2;
	localparam logic [7:0] LAST_BIT = 8'(FRAME_BITS - 1);
	localparam logic [7:0] LAST_SLOT_BIT = 8'(SLOT_BITS - 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_TXDATA = 4'h8;
	localparam logic [3:0] ADR_RXDATA = 4'hC;
	localparam logic [3:0] SEL_ALL = 4'hF;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {BC_2M048, BC_4M096, BC_8M192, BC_16M384} bc_rate_t;
	typedef enum logic [1:0] {TX_WAIT, TX_SLOT, TX_REST} tx_state_t;

	typedef struct packed {
		logic [3:0] port_en;
		logic ext_clk_out;
		logic open_drain;
		logic async_mode;
		bc_rate_t bc_rate;
		logic bc_out;
		logic fs_4k;
		logic fs_out;
	} ctrl_t;
	localparam int CTRL_W = $bits(ctrl_t);
	localparam ctrl_t CTRL_RST = ctrl_t'(12'h000);

	typedef struct packed {
		logic rx_new;
		logic cfg_err;
		logic tx_full;
		logic tx_empty;
		logic [3:0] straps;
	} status_t;

	typedef struct packed {
		logic fs;
		logic bclk;
		logic [3:0] rxd;
		logic [3:0] den_n;
		logic [1:0] ext_clk;
	} pins_in_t;
	localparam int PIN_W = $bits(pins_in_t);
endpackage

/* pin_sync2.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync2 #(
	parameter int W = 1
) (
	// Clock
	input wire logic clk_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_st_t;

	sync_st_t s;
	sync_st_t n;

	// No reset: these are data stages, settled within two cycles
	always_comb begin
		n.meta = d_i;
		n.stable = s.meta;
	end

	always_ff @(posedge clk_i) begin
		s <= n;
	end

	assign q_o = s.stable;
endmodule

/* pcm_word_buffer.sv */
// Small valid/ready word buffer in front of the transmit slots
`timescale 1ns/10ps
module pcm_word_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} buf_st_t;

	buf_st_t s;
	buf_st_t n;
	logic push;
	logic pop;

	assign in_ready_o = s.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = s.cnt != '0;
	assign out_data_o = s.mem[s.rd];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wr] = in_data_i;
			n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : AW'(s.wr + 1'b1);
		end
		if (pop) begin
			n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : AW'(s.rd + 1'b1);
		end
		n.cnt = (AW+1)'(s.cnt + (AW+1)'(push) - (AW+1)'(pop));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

/* pcm_highway_port_pins.sv */
// PCM highway port pins: four serial ports, shared framing, async channel reuse
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module pcm_highway_port_pins (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Frame sync and bit clock pins
	input wire logic frame_sync_line_i,
	output logic frame_sync_line_o,
	output logic frame_sync_line_oe_o,
	input wire logic serial_bit_clock_line_i,
	output logic serial_bit_clock_line_o,
	output logic serial_bit_clock_line_oe_o,
	// Serial data pins
	input wire logic [3:0] pcm_rxd_i,
	output logic [3:0] pcm_txd_o,
	output logic [3:0] pcm_txd_oe_o,
	input wire logic [1:0] pcm_txd23_i,
	// Driver enable pins
	input wire logic port0_driver_enable_n_i,
	output logic port0_driver_enable_n_o,
	output logic port0_driver_enable_n_oe_o,
	input wire logic port1_driver_enable_n_i,
	output logic port1_driver_enable_n_o,
	output logic port1_driver_enable_n_oe_o,
	input wire logic port2_driver_enable_n_i,
	output logic port2_driver_enable_n_o,
	output logic port2_driver_enable_n_oe_o,
	input wire logic port3_driver_enable_n_i,
	output logic port3_driver_enable_n_o,
	output logic port3_driver_enable_n_oe_o,
	// Line controller channels
	input wire logic async_ch2_transmit_i,
	input wire logic async_ch3_transmit_i,
	input wire logic async_ch2_rts_n_i,
	input wire logic async_ch3_rts_n_i,
	output logic async_ch2_receive_o,
	output logic async_ch3_receive_o,
	output logic async_ch2_clear_to_send_o,
	output logic async_ch3_clear_to_send_o,
	output logic async_ch2_external_clock_o,
	output logic async_ch3_external_clock_o
);
	typedef struct packed {
		pcm_pins_pkg::ctrl_t ctrl;
		logic [3:0] straps;
		logic cfg_err;
		logic rx_new;
		logic clk_prev;
		logic fs_prev;
		logic [pcm_pins_pkg::DIV_W-1:0] div_cnt;
		logic gen_clk;
		logic [7:0] bit_cnt;
		pcm_pins_pkg::tx_state_t state;
		logic [31:0] tx_word;
		logic tx_have;
		logic [31:0] rx_sh;
		logic [31:0] rx_word;
		logic ack;
		logic [31:0] dat;
		logic fs_o;
		logic fs_oe;
		logic bc_o;
		logic bc_oe;
		logic [3:0] txd_o;
		logic [3:0] txd_oe;
		logic [3:0] den_o;
		logic [3:0] den_oe;
		logic [1:0] lc_rx;
		logic [1:0] lc_cts;
		logic [1:0] lc_clk;
	} st_t;

	st_t s;
	st_t n;
	pcm_pins_pkg::pins_in_t raw;
	pcm_pins_pkg::pins_in_t sy;
	pcm_pins_pkg::ctrl_t wr_ctrl;
	pcm_pins_pkg::status_t stat;
	pcm_pins_pkg::status_t wr_stat;
	logic clk_now;
	logic tick;
	logic frame_start;
	logic req;
	logic wr_ok;
	logic push;
	logic illegal;
	logic [3:0] vld;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [31:0] buf_out_data;

	assign raw.fs = frame_sync_line_i;
	assign raw.bclk = serial_bit_clock_line_i;
	assign raw.rxd = pcm_rxd_i;
	assign raw.den_n = {port3_driver_enable_n_i, port2_driver_enable_n_i,
		port1_driver_enable_n_i, port0_driver_enable_n_i};
	assign raw.ext_clk = pcm_txd23_i;

	pin_sync2 #(
		.W(pcm_pins_pkg::PIN_W)
	) u_sync (
		.clk_i(clk_i),
		.d_i(raw),
		.q_o(sy)
	);

	// Bit clock is ours when driven out, else the synchronised pin
	assign clk_now = s.ctrl.bc_out ? s.gen_clk : sy.bclk;
	assign tick = clk_now & ~s.clk_prev;
	assign frame_start = tick & (s.ctrl.fs_out ? (s.bit_cnt == pcm_pins_pkg::LAST_BIT)
		: (sy.fs & ~s.fs_prev));
	assign vld = {4{(s.state == pcm_pins_pkg::TX_SLOT) & s.tx_have & ~s.ctrl.async_mode}}
		& s.ctrl.port_en;

	assign req = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr_ok = wb_we_i & (wb_sel_i == pcm_pins_pkg::SEL_ALL);
	assign push = req & wr_ok & (wb_adr_i == pcm_pins_pkg::ADR_TXDATA);
	assign wr_ctrl = pcm_pins_pkg::ctrl_t'(wb_dat_i[pcm_pins_pkg::CTRL_W-1:0]);
	assign illegal = (wr_ctrl.fs_out & wr_ctrl.fs_4k) //R1
		| (wr_ctrl.fs_4k & (wr_ctrl.bc_out | (wr_ctrl.bc_rate != pcm_pins_pkg::BC_2M048))); //R2
	assign wr_stat = pcm_pins_pkg::status_t'(wb_dat_i[7:0]);
	assign stat = '{rx_new: s.rx_new, cfg_err: s.cfg_err, tx_full: ~buf_in_ready,
		tx_empty: ~buf_out_valid, straps: s.straps};

	// Transmit words wait here; a full buffer holds off the bus ack
	pcm_word_buffer #(
		.WIDTH(32),
		.DEPTH(pcm_pins_pkg::BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(buf_in_ready),
		.in_data_i(wb_dat_i),
		.out_valid_o(buf_out_valid),
		.out_ready_i(frame_start),
		.out_data_o(buf_out_data)
	);

	always_comb begin
		n = s;
		// Register access
		n.ack = req & ~(push & ~buf_in_ready);
		if (n.ack) begin
			if (wb_adr_i == pcm_pins_pkg::ADR_CTRL) begin
				n.dat = {20'h00000, s.ctrl};
				if (wr_ok && illegal) begin
					n.cfg_err = 1'b1; //R1
				end else if (wr_ok) begin
					n.ctrl = wr_ctrl; //R3
				end
			end else if (wb_adr_i == pcm_pins_pkg::ADR_STATUS) begin
				n.dat = {24'h000000, stat};
				if (wr_ok && wr_stat.cfg_err) begin
					n.cfg_err = 1'b0;
				end
			end else if (wb_adr_i == pcm_pins_pkg::ADR_RXDATA) begin
				n.dat = s.rx_word;
				n.rx_new = 1'b0;
			end else begin
				n.dat = pcm_pins_pkg::WORD_ZERO;
			end
		end
		// Internal bit clock divider
		if (s.div_cnt == pcm_pins_pkg::DIV_LAST) begin
			n.div_cnt = '0;
			n.gen_clk = ~s.gen_clk;
		end else begin
			n.div_cnt = pcm_pins_pkg::DIV_W'(s.div_cnt + 1'b1);
		end
		n.clk_prev = clk_now;
		// Slot engine, one step per bit clock rising edge
		if (tick) begin
			n.fs_prev = sy.fs;
			if (frame_start) begin
				n.bit_cnt = '0;
				n.state = pcm_pins_pkg::TX_SLOT;
				n.tx_have = buf_out_valid;
				n.tx_word = buf_out_valid ? buf_out_data : pcm_pins_pkg::WORD_ZERO;
			end else begin
				n.bit_cnt = 8'(s.bit_cnt + 1'b1);
				if (s.state == pcm_pins_pkg::TX_SLOT) begin
					for (int p = 0; p < pcm_pins_pkg::PORTS; p++) begin
						n.tx_word[8*p+:8] = {s.tx_word[8*p+:7], 1'b0};
						n.rx_sh[8*p+:8] = {s.rx_sh[8*p+:7], sy.rxd[p]};
					end
					if (s.bit_cnt == pcm_pins_pkg::LAST_SLOT_BIT) begin
						n.state = pcm_pins_pkg::TX_REST;
						n.rx_word = n.rx_sh;
						n.rx_new = 1'b1;
					end
				end
			end
		end
		// Framing pins
		n.fs_o = s.ctrl.fs_out & (s.bit_cnt == pcm_pins_pkg::LAST_BIT); //R1
		n.fs_oe = s.ctrl.fs_out; //R1
		n.bc_o = s.gen_clk; //R3
		n.bc_oe = s.ctrl.bc_out; //R3
		// PCM data and driver enables
		for (int p = 0; p < pcm_pins_pkg::PORTS; p++) begin
			n.txd_o[p] = vld[p] & s.tx_word[8*p+7]; //R6
			n.txd_oe[p] = vld[p] & ~(s.ctrl.open_drain && p < 2 && s.tx_word[8*p+7]); //R5
			n.den_o[p] = ~vld[p]; //R4
			n.den_oe[p] = 1'b1; //R10
		end
		// Line controller reuse of the port pins
		if (s.ctrl.async_mode) begin
			n.txd_o[0] = async_ch2_transmit_i; //R7
			n.txd_oe[0] = ~(s.ctrl.open_drain & async_ch2_transmit_i); //R7
			n.txd_o[1] = async_ch3_transmit_i; //R7
			n.txd_oe[1] = ~(s.ctrl.open_drain & async_ch3_transmit_i); //R7
			n.den_o[0] = async_ch2_rts_n_i; //R8
			n.den_o[1] = async_ch3_rts_n_i; //R9
			n.txd_o[3:2] = {2{s.ctrl.ext_clk_out & s.gen_clk}}; //R6
			n.txd_oe[3:2] = {2{s.ctrl.ext_clk_out}}; //R6
		end
		n.lc_rx = {sy.rxd[1], sy.rxd[0]}; //R7
		n.lc_cts = {sy.rxd[3], sy.rxd[2]}; //R8
		n.lc_clk = s.ctrl.ext_clk_out ? {2{s.gen_clk}} : sy.ext_clk; //R6
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= st_t'('0); //R5
			s.straps <= sy.den_n; //R10
		end else begin
			s <= n;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign frame_sync_line_o = s.fs_o;
	assign frame_sync_line_oe_o = s.fs_oe;
	assign serial_bit_clock_line_o = s.bc_o;
	assign serial_bit_clock_line_oe_o = s.bc_oe;
	assign pcm_txd_o = s.txd_o;
	assign pcm_txd_oe_o = s.txd_oe;
	assign port0_driver_enable_n_o = s.den_o[0];
	assign port0_driver_enable_n_oe_o = s.den_oe[0];
	assign port1_driver_enable_n_o = s.den_o[1];
	assign port1_driver_enable_n_oe_o = s.den_oe[1];
	assign port2_driver_enable_n_o = s.den_o[2];
	assign port2_driver_enable_n_oe_o = s.den_oe[2];
	assign port3_driver_enable_n_o = s.den_o[3];
	assign port3_driver_enable_n_oe_o = s.den_oe[3];
	assign async_ch2_receive_o = s.lc_rx[0];
	assign async_ch3_receive_o = s.lc_rx[1];
	assign async_ch2_clear_to_send_o = s.lc_cts[0];
	assign async_ch3_clear_to_send_o = s.lc_cts[1];
	assign async_ch2_external_clock_o = s.lc_clk[0];
	assign async_ch3_external_clock_o = s.lc_clk[1];

	// Checks
	property p_refuse_bad_cfg;
		@(posedge clk_i) disable iff (rst_i)
		(req && wr_ok && wb_adr_i == pcm_pins_pkg::ADR_CTRL && illegal)
		|=> s.cfg_err && s.ctrl == $past(s.ctrl);
	endproperty
	a_refuse_bad_cfg: assert property (p_refuse_bad_cfg) else $error("bad config stored"); //R1

	property p_fs4k_needs_2m_in;
		@(posedge clk_i) disable iff (rst_i)
		s.ctrl.fs_4k |-> !s.ctrl.fs_out && !s.ctrl.bc_out
			&& s.ctrl.bc_rate == pcm_pins_pkg::BC_2M048;
	endproperty
	a_fs4k_needs_2m_in: assert property (p_fs4k_needs_2m_in) else $error("4k sync clock"); //R2

	property p_bclk_dir;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> serial_bit_clock_line_oe_o == $past(s.ctrl.bc_out);
	endproperty
	a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock direction wrong"); //R3

	property p_den_tracks_valid;
		@(posedge clk_i) disable iff (rst_i)
		!s.ctrl.async_mode |=> {port1_driver_enable_n_o, port0_driver_enable_n_o,
			port3_driver_enable_n_o, port2_driver_enable_n_o}
			== ~{$past(vld[1:0]), $past(vld[3:2])};
	endproperty
	a_den_tracks_valid: assert property (p_den_tracks_valid) else $error("enable mismatch"); //R4

	property p_txd01_float;
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> pcm_txd_oe_o[1:0] == 2'b00;
	endproperty
	a_txd01_float: assert property (p_txd01_float) else $error("port 0/1 driven in reset"); //R5

	property p_txd23_weak;
		@(posedge clk_i) disable iff (rst_i)
		(!s.ctrl.async_mode && vld[3:2] == 2'b00) |=> pcm_txd_oe_o[3:2] == 2'b00
			&& pcm_txd_o[3:2] == 2'b00;
	endproperty
	a_txd23_weak: assert property (p_txd23_weak) else $error("port 2/3 not weak low"); //R6

	property p_ch2_transmit;
		@(posedge clk_i) disable iff (rst_i)
		(s.ctrl.async_mode && !s.ctrl.open_drain) |=> pcm_txd_oe_o[0]
			&& pcm_txd_o[0] == $past(async_ch2_transmit_i);
	endproperty
	a_ch2_transmit: assert property (p_ch2_transmit) else $error("channel 2 data lost"); //R7

	property p_ch2_rts;
		@(posedge clk_i) disable iff (rst_i)
		s.ctrl.async_mode |=> port0_driver_enable_n_o == $past(async_ch2_rts_n_i);
	endproperty
	a_ch2_rts: assert property (p_ch2_rts) else $error("channel 2 request wrong"); //R8

	property p_ch3_cts;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> async_ch3_clear_to_send_o == $past(pcm_rxd_i[3], 3);
	endproperty
	a_ch3_cts: assert property (p_ch3_cts) else $error("channel 3 clear wrong"); //R9

	property p_strap_release;
		@(posedge clk_i) disable iff (1'b0)
		rst_i ##1 !rst_i |=> {port3_driver_enable_n_oe_o, port0_driver_enable_n_oe_o}
			== 2'b11 && port0_driver_enable_n_o && port3_driver_enable_n_o;
	endproperty
	a_strap_release: assert property (p_strap_release) else $error("enable not high"); //R10

	property p_strap_float;
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !port1_driver_enable_n_oe_o && !port2_driver_enable_n_oe_o;
	endproperty
	a_strap_float: assert property (p_strap_float) else $error("enable driven in reset"); //R10

	c_frame_with_word: cover property (@(posedge clk_i) disable iff (rst_i)
		frame_start && buf_out_valid);
	c_async_mode: cover property (@(posedge clk_i) disable iff (rst_i)
		s.ctrl.async_mode && !async_ch2_rts_n_i);
	c_cfg_refused: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s.cfg_err));
endmodule

/* pcm_highway_model.sv */
// Behavioural highway partner: bit clock, frame sync and receive data
`timescale 1ns/10ps
module pcm_highway_model #(
	parameter int HALF_NS = 400
) (
	// Word to send, byte p on port p
	input wire logic [31:0] rx_word_i,
	// Highway lines
	output logic bclk_o,
	output logic fs_o,
	output logic [3:0] rxd_o
);
	logic [7:0] cnt_q = 8'hFE;
	initial begin
		bclk_o = 1'b0;
		fs_o = 1'b0;
		rxd_o = 4'h0;
	end
	always #(HALF_NS) bclk_o = ~bclk_o;
	// Lines change on the falling edge, ready for the next rise
	always @(negedge bclk_o) begin
		cnt_q <= cnt_q + 8'h01;
		fs_o <= (cnt_q == 8'hFF);
		for (int p = 0; p < 4; p++) begin
			if (cnt_q < 8'h08)
				rxd_o[p] <= rx_word_i[8 * p + 7 - cnt_q[2:0]];
			else
				rxd_o[p] <= cnt_q[0];
		end
	end
endmodule

/* pcm_highway_port_pins_tb_top.sv */
// Self-checking bench for the highway pin block
`timescale 1ns/10ps
module pcm_highway_port_pins_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, t2 = 1'b0, t3 = 1'b0, r2 = 1'b1, r3 = 1'b1;
	logic use_tb = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0, straps = 4'hA, rxd_tb = 4'h0;
	logic [1:0] t23 = 2'b00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rxw = 32'h96E1_3C5A;
	logic [31:0] w [3] = '{32'h81C3_5AA5, 32'h0FF0_6699, 32'hE718_3CC4};
	logic [11:0] cv [8] = '{12'h003, 12'h006, 12'h00A, 12'h002, 12'h008, 12'h010, 12'h01D, 12'h000};
	logic [7:0] ok = 8'hF8;
	wire [31:0] rdat;
	wire ack, fs_o, fs_oe, bc_o, bc_oe, m_fs, m_bc, rx2, rx3, cts2, cts3, ec2, ec3;
	wire [3:0] txd_o, txd_oe, den_o, den_oe, m_rxd;
	// Enable pins float onto their strap resistors while the block is in reset
	wire [3:0] den_pin = rst_i ? straps : ((den_oe & den_o) | (~den_oe & straps));
	wire [3:0] rxd_pin = use_tb ? rxd_tb : m_rxd;
	wire [1:0] txd23 = (txd_oe[3:2] & txd_o[3:2]) | (~txd_oe[3:2] & t23);
	wire fs_pin = fs_oe ? fs_o : m_fs;
	wire bc_pin = bc_oe ? bc_o : m_bc;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int lo [4];
	logic [7:0] txb [4];
	time t;
	logic v;
	logic [31:0] junk;

	always #50 clk_i = ~clk_i;

	pcm_highway_model pcm_highway_model_i (.rx_word_i(rxw), .bclk_o(m_bc), .fs_o(m_fs),
		.rxd_o(m_rxd));
	pcm_highway_port_pins pcm_highway_port_pins_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.frame_sync_line_i(fs_pin), .frame_sync_line_o(fs_o), .frame_sync_line_oe_o(fs_oe),
		.serial_bit_clock_line_i(bc_pin), .serial_bit_clock_line_o(bc_o),
		.serial_bit_clock_line_oe_o(bc_oe), .pcm_rxd_i(rxd_pin), .pcm_txd_o(txd_o),
		.pcm_txd_oe_o(txd_oe), .pcm_txd23_i(txd23),
		.port0_driver_enable_n_i(den_pin[0]), .port0_driver_enable_n_o(den_o[0]),
		.port0_driver_enable_n_oe_o(den_oe[0]), .port1_driver_enable_n_i(den_pin[1]),
		.port1_driver_enable_n_o(den_o[1]), .port1_driver_enable_n_oe_o(den_oe[1]),
		.port2_driver_enable_n_i(den_pin[2]), .port2_driver_enable_n_o(den_o[2]),
		.port2_driver_enable_n_oe_o(den_oe[2]), .port3_driver_enable_n_i(den_pin[3]),
		.port3_driver_enable_n_o(den_o[3]), .port3_driver_enable_n_oe_o(den_oe[3]),
		.async_ch2_transmit_i(t2), .async_ch3_transmit_i(t3), .async_ch2_rts_n_i(r2),
		.async_ch3_rts_n_i(r3), .async_ch2_receive_o(rx2), .async_ch3_receive_o(rx3),
		.async_ch2_clear_to_send_o(cts2), .async_ch3_clear_to_send_o(cts3),
		.async_ch2_external_clock_o(ec2), .async_ch3_external_clock_o(ec3)
	);

	// Length of each enable-low run and the bits seen mid-bit on the transmit pin
	always @(posedge clk_i)
		for (int p = 0; p < 4; p++)
			if (den_pin[p] === 1'b0) begin
				if (lo[p] % 8 == 3)
					txb[p] <= {txb[p][6:0], txd_o[p]};
				lo[p] <= lo[p] + 1;
			end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic wr_en, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr_en;
		adr <= a;
		sel <= s;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, 4'hF, d, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 4'hF, 32'h0, q);
		chk(q, e);
	endtask

	// One frame: enable-low length per port and the byte it carried
	task automatic slot(input logic [31:0] wd, input logic [3:0] en);
		@(posedge fs_pin);
		foreach (lo[p]) lo[p] = 0;
		repeat (200) @(posedge clk_i);
		for (int p = 0; p < 4; p++) begin
			chk(32'(lo[p]), en[p] ? 32'd64 : 32'd0);
			if (en[p]) chk(32'(txb[p]), 32'(wd[8 * p +: 8]));
		end
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		#1 chk({den_oe, txd_oe, txd_o}, 32'h0);
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({den_oe, den_o, txd_oe, txd_o}, 32'hFF00);
		rd(4'h4, 32'h1A);
		$display("test reset done");
		// Let the first slot of the first highway frame end, then take its word, which clears the flag
		@(negedge fs_pin);
		repeat (80) @(posedge clk_i);
		rd(4'hC, rxw);
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, 32'(cv[i]));
			if (ok[i]) v = 1'b1;
			rd(4'h0, ok[i] ? 32'(cv[i]) : 32'h0);
			rd(4'h4, ok[i] ? 32'h1A : 32'h5A);
			wr(4'h4, 32'h40);
		end
		// Partial select and unmapped place change nothing
		wb(1'b1, 4'h0, 4'h3, 32'h0F00, junk);
		rd(4'h0, 32'h0);
		wr(4'h2, 32'hFFFF);
		rd(4'h2, 32'h0);
		$display("test config done");
		wr(4'h0, 32'h005);
		@(posedge bc_o);
		t = $time;
		@(negedge bc_o);
		chk(32'(($time - t) / 100), 32'd4);
		@(posedge fs_o);
		t = $time;
		@(posedge fs_o);
		chk(32'(($time - t) / 100), 32'd2048);
		chk({fs_oe, bc_oe}, 32'h3);
		wr(4'h0, 32'h000);
		$display("test clock out done");
		wr(4'h0, 32'hF00);
		@(negedge fs_pin);
		repeat (4) @(posedge clk_i);
		// Frames of the clock-out test left the receive flag set
		wb(1'b0, 4'hC, 4'hF, 32'h0, junk);
		wr(4'h8, w[0]);
		wr(4'h8, w[1]);
		rd(4'h4, 32'h2A);
		// Third push stalls until a frame start frees a place
		wr(4'h8, w[2]);
		slot(w[1], 4'hF);
		rd(4'h4, 32'h8A);
		rd(4'hC, rxw);
		wr(4'h0, 32'hB00);
		slot(w[2], 4'hB);
		slot(32'h0, 4'h0);
		$display("test pcm slots done");
		use_tb <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(4'h0, i ? 32'hE0 : 32'h20);
			v = i[0];
			t2 <= v;
			t3 <= ~v;
			r2 <= v;
			r3 <= ~v;
			rxd_tb <= v ? 4'h5 : 4'hA;
			t23 <= v ? 2'b01 : 2'b10;
			repeat (6) @(posedge clk_i);
			#1 chk(txd_oe[1:0], v ? 32'h2 : 32'h3);
			chk(txd_o[1:0] & txd_oe[1:0], {~v, v} & txd_oe[1:0]);
			chk({den_oe, den_o}, {4'hF, 2'b11, ~v, v});
			chk({cts3, cts2, rx3, rx2}, rxd_tb);
			chk(txd_oe[3:2], v ? 32'h3 : 32'h0);
			if (!v) chk({ec3, ec2}, t23);
		end
		$display("test async done");
		print_verdict();
	end
endmodule
